// ---- hw/slp_status_leds.sv ----
// Status indicator pattern generator with an AHB-Lite register slave.
// Assumes all state inputs are synchronous to hclk and held as levels.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.

// Function
// - Network green off in INIT
// - Network green blinks in PRE-OPERATIONAL
// - Network green single flash in SAFE-OPERATIONAL
// - Network green steady on in OPERATIONAL
// - Network green flickers in BOOTSTRAP
// - Network red off without errors
// - Network red double flash on watchdog
// - Network red single flash on internal error
// - Network red blinks on configuration error
// - Blink toggles at about 2.5 Hz
// - Flicker toggles at about 10 Hz
// - Flash 0.2 s, then 1 s pause
// - Power stage off: green slow, red off
// - Power enabled: green on, red off
// - Fault: green off, red on
// - Fault reaction: both device LEDs on
// - No firmware: green flashes, red on
// - Device flash 0.9 s off, 0.1 s on
// - Slow blink toggles at about 1 Hz
// - Port LED off, on, or flicker
// - Port logic replicated for both ports
module slp_status_leds
    import slp_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Fieldbus state and errors
    input  wire logic [3:0]  communication_state,
    input  wire logic        err_watchdog,
    input  wire logic        err_internal,
    input  wire logic        err_config,
    // Drive state and firmware
    input  wire logic [2:0]  drive_state,
    input  wire logic        fw_invalid,
    input  wire logic        fw_download,
    // Port link state
    input  wire logic [1:0]  port_open,
    input  wire logic [1:0]  port_activity,
    // Indicators, high lights the LED
    output logic             fieldbus_status_indicator_green,
    output logic             fieldbus_status_indicator_red,
    output logic             device_status_green,
    output logic             device_status_red,
    output logic [1:0]       port_link_green
);

    // ------------------------------------------------------------------
    // Pattern helpers
    // ------------------------------------------------------------------

    // Length of one repetition of a pattern, in ticks
    function automatic logic [5:0] pat_period(input slp_pattern_type p);
        logic [5:0] r;
        r = 6'h01;
        unique case (p)
            PAT_OFF,
            PAT_ON:      r = 6'h01;
            PAT_BLINK:   r = 6'(BLINK_T + BLINK_T);
            PAT_FLICKER: r = 6'(FLICK_T + FLICK_T);
            PAT_SFLASH:  r = 6'(FLASH_T + GAP_T);
            PAT_DFLASH:  r = 6'(FLASH_T + FLASH_T + FLASH_T + GAP_T);
            PAT_SLOW:    r = 6'(SLOW_T + SLOW_T);
            PAT_FWFLASH: r = 6'(FWOFF_T + FWON_T);
        endcase
        return r;
    endfunction

    // LED level for a pattern at a given phase; every pattern starts at phase zero
    function automatic logic pat_level(input slp_pattern_type p, input logic [5:0] ph);
        logic r;
        r = 1'b0;
        unique case (p)
            PAT_OFF:     r = 1'b0;
            PAT_ON:      r = 1'b1;
            PAT_BLINK:   r = (ph < BLINK_T);
            PAT_FLICKER: r = (ph < FLICK_T);
            PAT_SFLASH:  r = (ph < FLASH_T);
            PAT_DFLASH:  r = (ph < FLASH_T) ||
                             ((ph >= 6'(FLASH_T + FLASH_T)) &&
                              (ph < 6'(FLASH_T + FLASH_T + FLASH_T)));
            PAT_SLOW:    r = (ph < SLOW_T);
            PAT_FWFLASH: r = (ph >= FWOFF_T);
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [1:0]  ctrl_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;
    logic        addr_phase;
    logic [5:0]  leds_q;
    slp_pattern_type pat_sel [NUM_LEDS];
    logic [PAT_W*NUM_LEDS-1:0] pat_flat;

    // Zero wait states, never an error
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_q;
    assign addr_phase = hsel && htrans[1] && hready;

    // Remember a write address for its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // Control register: enable and lamp test; only the low two bits exist
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
            ctrl_q <= hwdata[1:0];
        end
    end

    // Read data captured in the address phase; a write still in its data
    // phase is forwarded so a read right behind it sees the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                ADDR_CTRL: begin
                    if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
                        rdata_q <= {30'h0000_0000, hwdata[1:0]};
                    end else begin
                        rdata_q <= {30'h0000_0000, ctrl_q};
                    end
                end
                ADDR_STATUS:  rdata_q <= {26'h000_0000, leds_q};
                ADDR_PATTERN: rdata_q <= {14'h0000, pat_flat};
                default:      rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    logic [31:0] presc_q;
    logic        tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= 32'h0000_0000;
        end else if (presc_q == 32'(TICK_CYC - 1)) begin
            presc_q <= 32'h0000_0000;
        end else begin
            presc_q <= presc_q + 32'h0000_0001;
        end
    end

    assign tick = (presc_q == 32'(TICK_CYC - 1));

    // ------------------------------------------------------------------
    // Pattern selection
    // ------------------------------------------------------------------

    // Network green follows the fieldbus state; unknown codes stay dark
    always_comb begin
        unique case (communication_state)
            COMM_INIT:   pat_sel[LED_NET_G] = PAT_OFF;
            COMM_PREOP:  pat_sel[LED_NET_G] = PAT_BLINK;
            COMM_SAFEOP: pat_sel[LED_NET_G] = PAT_SFLASH;
            COMM_OP:     pat_sel[LED_NET_G] = PAT_ON;
            COMM_BOOT:   pat_sel[LED_NET_G] = PAT_FLICKER;
            default:     pat_sel[LED_NET_G] = PAT_OFF;
        endcase
    end

    // Network red shows only the highest-ranked error
    always_comb begin
        if (err_watchdog) begin
            pat_sel[LED_NET_R] = PAT_DFLASH;
        end else if (err_internal) begin
            pat_sel[LED_NET_R] = PAT_SFLASH;
        end else if (err_config) begin
            pat_sel[LED_NET_R] = PAT_BLINK;
        end else begin
            pat_sel[LED_NET_R] = PAT_OFF;
        end
    end

    // Device pair; missing firmware overrides the drive state, since the
    // drive state machine is meaningless without running firmware
    always_comb begin
        if (fw_invalid || fw_download) begin
            pat_sel[LED_DEV_G] = PAT_FWFLASH;
            pat_sel[LED_DEV_R] = PAT_ON;
        end else begin
            unique case (drive_state)
                DRV_SW_ON_DIS,
                DRV_READY,
                DRV_SWITCHED: begin
                    pat_sel[LED_DEV_G] = PAT_SLOW;
                    pat_sel[LED_DEV_R] = PAT_OFF;
                end
                DRV_OP_ENABLE,
                DRV_QUICK_STOP: begin
                    pat_sel[LED_DEV_G] = PAT_ON;
                    pat_sel[LED_DEV_R] = PAT_OFF;
                end
                DRV_FAULT_REAC: begin
                    pat_sel[LED_DEV_G] = PAT_ON;
                    pat_sel[LED_DEV_R] = PAT_ON;
                end
                DRV_FAULT: begin
                    pat_sel[LED_DEV_G] = PAT_OFF;
                    pat_sel[LED_DEV_R] = PAT_ON;
                end
                default: begin
                    pat_sel[LED_DEV_G] = PAT_OFF;
                    pat_sel[LED_DEV_R] = PAT_ON;
                end
            endcase
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        always_comb begin
            if (!port_open[p]) begin
                pat_sel[LED_PORT0 + p] = PAT_OFF;
            end else if (port_activity[p]) begin
                pat_sel[LED_PORT0 + p] = PAT_FLICKER;
            end else begin
                pat_sel[LED_PORT0 + p] = PAT_ON;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-LED phase counters and output flops
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_LEDS; i++) begin : g_led
        slp_pattern_type prev_q;
        logic [5:0]      phase_q;

        assign pat_flat[PAT_W*i +: PAT_W] = pat_sel[i];

        // restart the pattern when its selection changes
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                prev_q  <= PAT_OFF;
                phase_q <= 6'h00;
            end else begin
                prev_q <= pat_sel[i];
                if (pat_sel[i] != prev_q) begin
                    phase_q <= 6'h00;
                end else if (tick) begin
                    if (phase_q >= 6'(pat_period(pat_sel[i]) - 6'h01)) begin
                        phase_q <= 6'h00;
                    end else begin
                        phase_q <= phase_q + 6'h01;
                    end
                end
            end
        end

        // Gate with enable; lamp test lights everything to check the lamps
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                leds_q[i] <= 1'b0;
            end else if (!ctrl_q[CTRL_EN_BIT]) begin
                leds_q[i] <= 1'b0;
            end else if (ctrl_q[CTRL_LT_BIT]) begin
                leds_q[i] <= 1'b1;
            end else if (pat_sel[i] != prev_q) begin
                leds_q[i] <= pat_level(pat_sel[i], 6'h00);
            end else begin
                leds_q[i] <= pat_level(pat_sel[i], phase_q);
            end
        end
    end

    // Pins come straight from the output flops
    assign fieldbus_status_indicator_green = leds_q[LED_NET_G];
    assign fieldbus_status_indicator_red   = leds_q[LED_NET_R];
    assign device_status_green             = leds_q[LED_DEV_G];
    assign device_status_red               = leds_q[LED_DEV_R];
    assign port_link_green                 = leds_q[LED_PORT1:LED_PORT0];

endmodule

// ---- hw/slp_pkg.sv ----
// Constants and types for the status indicator pattern generator.
// Assumes a single 100 MHz clock; all pattern timing is counted in time base ticks.
package slp_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int TICK_MS       = 50;
    localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

    // Pattern times in milliseconds, as specified
    localparam int BLINK_HALF_MS = 200;   // 2.5 Hz blink, half period
    localparam int FLICK_HALF_MS = 50;    // 10 Hz flicker, half period
    localparam int FLASH_ON_MS   = 200;   // network flash length
    localparam int FLASH_GAP_MS  = 1000;  // pause after a flash group
    localparam int SLOW_HALF_MS  = 500;   // 1 Hz slow blink, half period
    localparam int FW_OFF_MS     = 900;   // firmware flash, dark part
    localparam int FW_ON_MS      = 100;   // firmware flash, lit part

    // Pattern times in ticks
    localparam logic [5:0] BLINK_T = 6'(BLINK_HALF_MS / TICK_MS);
    localparam logic [5:0] FLICK_T = 6'(FLICK_HALF_MS / TICK_MS);
    localparam logic [5:0] FLASH_T = 6'(FLASH_ON_MS / TICK_MS);
    localparam logic [5:0] GAP_T   = 6'(FLASH_GAP_MS / TICK_MS);
    localparam logic [5:0] SLOW_T  = 6'(SLOW_HALF_MS / TICK_MS);
    localparam logic [5:0] FWOFF_T = 6'(FW_OFF_MS / TICK_MS);
    localparam logic [5:0] FWON_T  = 6'(FW_ON_MS / TICK_MS);

    // ------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_PATTERN = 8'h08;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_LT_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h1;
    localparam int          PAT_W        = 3;
    localparam int          NUM_LEDS     = 6;

    // LED slots
    localparam int LED_NET_G  = 0;
    localparam int LED_NET_R  = 1;
    localparam int LED_DEV_G  = 2;
    localparam int LED_DEV_R  = 3;
    localparam int LED_PORT0  = 4;
    localparam int LED_PORT1  = 5;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PAT_OFF     = 3'b000,
        PAT_ON      = 3'b001,
        PAT_BLINK   = 3'b010,
        PAT_FLICKER = 3'b011,
        PAT_SFLASH  = 3'b100,
        PAT_DFLASH  = 3'b101,
        PAT_SLOW    = 3'b110,
        PAT_FWFLASH = 3'b111
    } slp_pattern_type;

    // Fieldbus state machine codes
    localparam logic [3:0] COMM_INIT   = 4'h1;
    localparam logic [3:0] COMM_PREOP  = 4'h2;
    localparam logic [3:0] COMM_BOOT   = 4'h3;
    localparam logic [3:0] COMM_SAFEOP = 4'h4;
    localparam logic [3:0] COMM_OP     = 4'h8;

    // Drive state machine codes
    localparam logic [2:0] DRV_SW_ON_DIS  = 3'h0;
    localparam logic [2:0] DRV_READY      = 3'h1;
    localparam logic [2:0] DRV_SWITCHED   = 3'h2;
    localparam logic [2:0] DRV_OP_ENABLE  = 3'h3;
    localparam logic [2:0] DRV_QUICK_STOP = 3'h4;
    localparam logic [2:0] DRV_FAULT_REAC = 3'h5;
    localparam logic [2:0] DRV_FAULT      = 3'h6;

endpackage

// ---- sim/slp_status_leds_asserts.sv ----
// Checker for the status indicator generator, bound to its top module.
// Assumes one bus slave and level inputs synchronous to hclk.
module slp_status_leds_asserts
    import slp_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [3:0]  communication_state,
    input wire logic        err_watchdog,
    input wire logic        err_internal,
    input wire logic        err_config,
    input wire logic [2:0]  drive_state,
    input wire logic        fw_invalid,
    input wire logic        fw_download,
    input wire logic [1:0]  port_open,
    input wire logic [1:0]  port_activity,
    input wire logic        fieldbus_status_indicator_green,
    input wire logic        fieldbus_status_indicator_red,
    input wire logic        device_status_green,
    input wire logic        device_status_red,
    input wire logic [1:0]  port_link_green
);
    logic        wa_q;
    logic [1:0]  ctrl_q;
    logic [1:0]  up_q;
    logic [15:0] flk_q;
    logic [15:0] hi_q;
    logic        ok;

    // Control shadow; disable and lamp test override every pattern
    assign ok = (ctrl_q == 2'h1) && (up_q == 2'h3);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wa_q   <= 1'b0;
            ctrl_q <= CTRL_RESET;
            up_q   <= 2'h0;
        end else begin
            wa_q <= hsel && htrans[1] && hwrite && (haddr[7:0] == ADDR_CTRL);
            if (wa_q) begin
                ctrl_q <= hwdata[1:0];
            end
            if (up_q != 2'h3) begin
                up_q <= up_q + 2'h1;
            end
        end
    end

    // Age of a steady port 0 flicker, and length of its lit run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flk_q <= 16'h0;
            hi_q  <= 16'h0;
        end else begin
            flk_q <= (ok && port_open[0] && port_activity[0])
                   ? flk_q + 16'(flk_q != 16'hFFFF) : 16'h0;
            hi_q  <= port_link_green[0] ? hi_q + 16'h1 : 16'h0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Three normal samples, so the registered LEDs have caught up
    sequence s_settled;
        ok && $past(ok) && $past(ok, 2);
    endsequence
    // First runs after a restart may be cut short or merge with a steady lit run, so only a long-steady flicker counts
    sequence s_flick_end;
        (flk_q > 3 * TICK_CYC) && $fell(port_link_green[0]);
    endsequence

    a_init_green_off: assert property (
        s_settled ##0 ($past(communication_state) == COMM_INIT)
        |-> !fieldbus_status_indicator_green) else $error("net green lit in init");
    a_op_green_on: assert property (
        s_settled ##0 ($past(communication_state) == COMM_OP)
        |-> fieldbus_status_indicator_green) else $error("net green dark in operational");
    a_red_quiet: assert property (
        s_settled ##0 ($past({err_watchdog, err_internal, err_config}) == 3'h0)
        |-> !fieldbus_status_indicator_red) else $error("net red lit without error");
    a_fault_leds: assert property (
        s_settled ##0 ($past(drive_state) == DRV_FAULT) ##0 !$past(fw_invalid || fw_download)
        |-> !device_status_green && device_status_red) else $error("fault lamps wrong");
    a_reaction_both: assert property (
        s_settled ##0 ($past(drive_state) == DRV_FAULT_REAC) ##0 !$past(fw_invalid || fw_download)
        |-> device_status_green && device_status_red) else $error("reaction lamps wrong");
    a_fw_red_on: assert property (
        s_settled ##0 $past(fw_invalid || fw_download)
        |-> device_status_red) else $error("device red dark without firmware");
    a_port_level: assert property (
        s_settled |-> ((port_link_green & ~$past(port_open)) == 2'h0)
        && ((~port_link_green & $past(port_open & ~port_activity)) == 2'h0))
        else $error("port lamp level wrong");
    a_flicker_half: assert property (
        s_flick_end |-> hi_q == TICK_CYC) else $error("flicker lit run wrong");
endmodule

// ---- sim/slp_led_viewer.sv ----
// Operator's view of the six lamps: lengths of lit and dark runs.
// Assumes lamps registered on hclk; clr restarts the longest dark run.
module slp_led_viewer #(
    parameter int N = 6
) (
    input  wire logic         hclk,
    input  wire logic         clr,
    input  wire logic [N-1:0] led,
    output logic [N-1:0][7:0] hi_len,
    output logic [N-1:0][7:0] lo_max
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0]      prev_q;
    logic [N-1:0][7:0] run_q;

    // Runs saturate, so a long dark spell never wraps into a short one
    always @(posedge hclk) begin
        for (int i = 0; i < N; i++) begin
            if (led[i] !== prev_q[i]) begin
                if (prev_q[i] === 1'b1) begin
                    hi_len[i] <= run_q[i];
                end else if (run_q[i] > lo_max[i]) begin
                    lo_max[i] <= run_q[i];
                end
                run_q[i] <= 8'h01;
            end else if (run_q[i] != 8'hFF) begin
                run_q[i] <= run_q[i] + 8'h01;
            end
            if (clr) begin
                lo_max[i] <= 8'h00;
            end
            prev_q[i] <= led[i];
        end
    end
endmodule

// ---- sim/tb_slp_status_leds.sv ----
// Self-checking bench for the status indicator generator.
// Assumes it is the only bus master; the tick is shrunk to keep runs short.
module tb_slp_status_leds
    import slp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TCK = 4;
    logic              hclk, hresetn, hsel, hwrite, hready, hresp, clr;
    logic [31:0]       haddr, hwdata, hrdata, rd;
    logic [1:0]        htrans, po, pa, plg;
    logic [2:0]        hsize, ds;
    logic [3:0]        cs;
    logic              wdg, ierr, cerr, fwi, fwd, ng, nr, dg, dr;
    logic [5:0]        leds;
    logic [5:0][7:0]   hl, lm;
    int                n_mismatch, compares;
    logic [3:0]        cs_tab [6] = '{COMM_INIT, COMM_PREOP, COMM_SAFEOP, COMM_OP, COMM_BOOT, 4'h0};

    assign leds = {plg, dr, dg, nr, ng};
    slp_status_leds #(.TICK_CYC(TCK)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .communication_state(cs),
        .err_watchdog(wdg), .err_internal(ierr), .err_config(cerr), .drive_state(ds),
        .fw_invalid(fwi), .fw_download(fwd), .port_open(po), .port_activity(pa),
        .fieldbus_status_indicator_green(ng), .fieldbus_status_indicator_red(nr),
        .device_status_green(dg), .device_status_red(dr), .port_link_green(plg));
    slp_led_viewer #(.N(6)) viewer (.hclk(hclk), .clr(clr), .led(leds), .hi_len(hl), .lo_max(lm));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // Expected pattern word: three bits a lamp, lamp slot order
    function automatic logic [31:0] exp_pat();
        slp_pattern_type p [6];
        p[0] = cs == COMM_PREOP ? PAT_BLINK : cs == COMM_SAFEOP ? PAT_SFLASH :
               cs == COMM_OP ? PAT_ON : cs == COMM_BOOT ? PAT_FLICKER : PAT_OFF;
        p[1] = wdg ? PAT_DFLASH : ierr ? PAT_SFLASH : cerr ? PAT_BLINK : PAT_OFF;
        p[2] = fwi || fwd ? PAT_FWFLASH : ds <= DRV_SWITCHED ? PAT_SLOW :
               ds <= DRV_FAULT_REAC ? PAT_ON : PAT_OFF;
        p[3] = fwi || fwd || ds >= DRV_FAULT_REAC ? PAT_ON : PAT_OFF;
        exp_pat = 32'h0;
        for (int i = 0; i < 6; i++) begin
            if (i > 3) begin
                p[i] = !po[i - 4] ? PAT_OFF : pa[i - 4] ? PAT_FLICKER : PAT_ON;
            end
            exp_pat[3 * i +: 3] = p[i];
        end
    endfunction

    task automatic runchk(input int i, input int hi, input int lo);
        chk($sformatf("lit run %0d", i), 32'(hi), {24'h0, hl[i]});
        chk($sformatf("dark run %0d", i), 32'(lo), {24'h0, lm[i]});
    endtask

    // Hold one lamp set steady, then measure settled runs on every lamp but device red
    task automatic phase(input logic [3:0] c, input logic f, input int gh, input int gl,
                         input int dh, input int dl);
        {cs, fwd, fwi, wdg, ierr, cerr, ds, po, pa} <= {c, f, 4'h7, DRV_SW_ON_DIS, 4'hF};
        @(posedge hclk);
        #1;
        chk("restart", 32'h1, {31'h0, ng});
        // A pattern that starts dark may merge with the old dark run; let it end
        repeat (100) @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        repeat (300) @(posedge hclk);
        #1;
        runchk(LED_NET_G, gh, gl);
        runchk(LED_NET_R, FLASH_T * TCK, GAP_T * TCK);
        runchk(LED_DEV_G, dh, dl);
        runchk(LED_PORT0, FLICK_T * TCK, FLICK_T * TCK);
        runchk(LED_PORT1, FLICK_T * TCK, FLICK_T * TCK);
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 1440 cycles
    initial begin
        repeat (6000) @(posedge hclk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        void'($urandom(20137));
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = {1'b0, 66'h0, 2'h0, 3'h2};
        {cs, wdg, ierr, cerr, ds, fwi, fwd, po, pa, clr} = 17'h1;
        n_mismatch = 0;
        compares = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Control word: disable, lamp test, read-only and unmapped places
        rdc("ctrl", ADDR_CTRL, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h0);
        // Lamps follow the control word one edge after it lands
        @(posedge hclk);
        rdc("status", ADDR_STATUS, 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h3);
        repeat (2) @(posedge hclk);
        bus(1'b1, ADDR_STATUS, 32'h0);
        rdc("status", ADDR_STATUS, 32'h3F);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h10, 32'h0);
        rdc("ctrl", ADDR_CTRL, 32'h3);
        bus(1'b1, ADDR_CTRL, 32'h1);
        // Every state code in turn, the rest drawn at random
        for (int k = 0; k < 48; k++) begin
            cs   <= cs_tab[k % 6];
            ds   <= 3'(k % 8);
            {wdg, ierr, cerr, po, pa} <= 7'($urandom);
            fwi  <= $urandom_range(0, 3) == 0;
            fwd  <= $urandom_range(0, 3) == 0;
            repeat (2) @(posedge hclk);
            rdc("pattern", ADDR_PATTERN, exp_pat());
        end
        phase(COMM_PREOP, 1'b0, BLINK_T * TCK, BLINK_T * TCK, SLOW_T * TCK, SLOW_T * TCK);
        phase(COMM_SAFEOP, 1'b1, FLASH_T * TCK, GAP_T * TCK, FWON_T * TCK, FWOFF_T * TCK);
        phase(COMM_BOOT, 1'b0, FLICK_T * TCK, FLICK_T * TCK, SLOW_T * TCK, SLOW_T * TCK);
        // Second reset in mid-run
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
        chk("lamps in reset", 32'h0, {26'h0, leds});
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("ctrl", ADDR_CTRL, 32'h1);
        end_of_test();
    end
endmodule

bind slp_status_leds slp_status_leds_asserts #(.TICK_CYC(TICK_CYC)) u_asserts (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .communication_state(communication_state),
    .err_watchdog(err_watchdog), .err_internal(err_internal), .err_config(err_config),
    .drive_state(drive_state), .fw_invalid(fw_invalid), .fw_download(fw_download),
    .port_open(port_open), .port_activity(port_activity), .port_link_green(port_link_green),
    .fieldbus_status_indicator_green(fieldbus_status_indicator_green),
    .fieldbus_status_indicator_red(fieldbus_status_indicator_red),
    .device_status_green(device_status_green), .device_status_red(device_status_red));
